//--- cell_balance_timer_cfg.svh
`ifndef CELL_BALANCE_TIMER_CFG_SVH
`define CELL_BALANCE_TIMER_CFG_SVH

// register offsets of the two countdown registers
`define CELL5_COUNTDOWN_OFFSET 16'h1025
`define CELL6_COUNTDOWN_OFFSET 16'h1026

// field positions
`define DURATION_MSB 13
`define DURATION_LSB 0
`define RESERVED_MSB 15
`define RESERVED_LSB 14

// reset, saturation and maximum values of the duration field
`define DURATION_RESET 14'h0000
`define DURATION_ELAPSED_VALUE 14'h0000
`define DURATION_MAX 14'h3FFF
`define RESERVED_VALUE 2'h0

// timing: one count is ten seconds of mclk at 25 MHz
`define MCLK_HZ 25000000
`define TICK_PERIOD_S 10
`define TICK_CYCLES (`MCLK_HZ * `TICK_PERIOD_S)
`define TICK_COUNT_WIDTH 28

`endif

//--- cell_balance_timer_pkg.sv
package cell_balance_timer_pkg;
    // duration field of one countdown register
    typedef logic [13:0] duration_t;
    // full register word
    typedef logic [15:0] reg_word_t;
    // register address
    typedef logic [15:0] reg_addr_t;
endpackage

//--- ten_second_tick.sv
`timescale 1ns/100ps
`include "cell_balance_timer_cfg.svh"

// free-running divider giving a one-cycle pulse once per period
module ten_second_tick #(
    parameter int unsigned PERIOD = `TICK_CYCLES
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // one-cycle tick
    output logic      tick
);
    logic [`TICK_COUNT_WIDTH-1:0] count_q;  // cycles into the period
    logic                         tick_q;   // registered tick
    wire                          wrap;     // last cycle of period

    // wrap one cycle before the period closes
    assign wrap = (count_q == `TICK_COUNT_WIDTH'(PERIOD - 1));
    assign tick = tick_q;

    // period counter and tick register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
            tick_q  <= 1'b0;
        end else begin
            count_q <= wrap ? '0 : count_q + 1'b1;
            tick_q  <= wrap;
        end
    end
endmodule

//--- balance_duration_counter.sv
`timescale 1ns/100ps
`include "cell_balance_timer_cfg.svh"

// one channel's saturating countdown of ten-second units
module balance_duration_counter (
    // clock and reset
    input  wire logic                              mclk,
    input  wire logic                              resetn,
    // software load
    input  wire logic                              load,
    input  wire cell_balance_timer_pkg::duration_t loadValue,
    // count control
    input  wire logic                              tick,
    input  wire logic                              countEnable,
    // state
    output cell_balance_timer_pkg::duration_t      count,
    output logic                                   balanceAllowed
);
    cell_balance_timer_pkg::duration_t count_q;    // remaining count
    cell_balance_timer_pkg::duration_t count_d;    // next count
    logic                              allowed_q;  // count not zero
    wire                               notElapsed; // count above zero
    wire                               step;       // decrement now

    assign notElapsed = (count_q != `DURATION_ELAPSED_VALUE);
    // decrement only on a tick, when enabled and above zero
    assign step = tick & countEnable & notElapsed;
    // a write wins over a tick in the same cycle
    assign count_d = load ? loadValue :
                     step ? count_q - 14'h0001 : count_q;
    assign count = count_q;
    assign balanceAllowed = allowed_q;

    // counter and zero flag
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_q   <= `DURATION_RESET;
            allowed_q <= 1'b0;
        end else begin
            count_q   <= count_d;
            allowed_q <= (count_d != `DURATION_ELAPSED_VALUE);
        end
    end
endmodule

//--- cell_balance_timer.sv
`timescale 1ns/100ps
`include "cell_balance_timer_cfg.svh"

// Operation
// - two timer registers, channels 5 and 6
// - bits 15:14 read zero, ignore writes
// - bits 13:0 hold count of ten seconds
// - read returns live remaining count
// - countdown saturates at zero, never wraps
// - zero count halts that channel's balancing
// - decrement only with all three enables
// - reset clears count, channel duration_elapsed_value
// - maximum count 3FFF, 163830 seconds
module cell_balance_timer #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    // clock and reset
    input  wire logic                              mclk,
    input  wire logic                              resetn,
    // register port
    input  wire cell_balance_timer_pkg::reg_addr_t regAddr,
    input  wire cell_balance_timer_pkg::reg_word_t regWdata,
    input  wire logic                              regWrite,
    input  wire logic                              regRead,
    output cell_balance_timer_pkg::reg_word_t      regRdata,
    // balancing enables
    input  wire logic                              balanceEnable,
    input  wire logic                              timerBalanceEnable,
    input  wire logic [1:0]                        channelEnable,
    // per-channel balancing permission, index 0 is cell 5
    output logic [1:0]                             balanceAllowed
);
    // number of channels kept here
    localparam int NCH = 2;

    // channel index from address, one-hot
    function automatic logic [1:0] channelHit(
        input cell_balance_timer_pkg::reg_addr_t addr
    );
        channelHit = {addr == `CELL6_COUNTDOWN_OFFSET,
                      addr == `CELL5_COUNTDOWN_OFFSET};
    endfunction

    // tick from divider
    wire                                tick;
    // register selected by address
    wire  [1:0]                         hit;
    // write and read selects per channel
    wire  [1:0]                         writeSel;
    wire  [1:0]                         readSel;
    // common enable of all channels
    wire                                globalRun;
    // per-channel count enable
    wire  [1:0]                         countEnable;
    // live counts
    cell_balance_timer_pkg::duration_t  count [NCH];
    // value written to the duration field
    cell_balance_timer_pkg::duration_t  writeValue;
    // read word before the output register
    cell_balance_timer_pkg::reg_word_t  readWord;
    // registered read data
    cell_balance_timer_pkg::reg_word_t  rdata_q;
    cell_balance_timer_pkg::reg_word_t  rdata_d;

    // address decode
    assign hit      = channelHit(regAddr);
    assign writeSel = hit & {NCH{regWrite}};
    assign readSel  = hit & {NCH{regRead}};
    // reserved bits are dropped on write
    assign writeValue = regWdata[`DURATION_MSB:`DURATION_LSB];
    // counting needs global and timer balancing plus channel enable
    assign globalRun   = balanceEnable & timerBalanceEnable;
    assign countEnable = channelEnable & {NCH{globalRun}};

    // read mux: live count, reserved bits zero, unmapped reads zero
    assign readWord =
        readSel[0] ? {`RESERVED_VALUE, count[0]} :
        readSel[1] ? {`RESERVED_VALUE, count[1]} :
                     16'h0000;
    // data stand only in the cycle after the read strobe
    assign rdata_d  = readWord;
    assign regRdata = rdata_q;

    // ten-second tick
    ten_second_tick #(
        .PERIOD (TICK_CYCLES)
    ) u_tick (
        .mclk   (mclk),
        .resetn (resetn),
        .tick   (tick)
    );

    // one counter per channel
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            // saturating countdown, write loads directly
            balance_duration_counter u_cnt (
                .mclk           (mclk),
                .resetn         (resetn),
                .load           (writeSel[gi]),
                .loadValue      (writeValue),
                .tick           (tick),
                .countEnable    (countEnable[gi]),
                .count          (count[gi]),
                .balanceAllowed (balanceAllowed[gi])
            );
        end
    endgenerate

    // read data register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // per-channel checks
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_chk
            // a write loads the written field next cycle
            property p_write_load;
                @(posedge mclk) disable iff (!resetn)
                writeSel[gi] |=> count[gi] == $past(writeValue);
            endproperty
            a_write_load: assert property (p_write_load)
                else $error("written count not loaded");

            // a read returns the count seen at the strobe
            property p_read_live;
                @(posedge mclk) disable iff (!resetn)
                readSel[gi] |=> regRdata[`DURATION_MSB:0] == $past(count[gi]);
            endproperty
            a_read_live: assert property (p_read_live)
                else $error("read data is not live count");

            // zero stays zero unless written
            property p_saturate;
                @(posedge mclk) disable iff (!resetn)
                (count[gi] == 14'h0000 && !writeSel[gi]) |=>
                    count[gi] == 14'h0000;
            endproperty
            a_saturate: assert property (p_saturate)
                else $error("count wrapped below zero");

            // permission follows a non-zero count
            property p_halt_at_zero;
                @(posedge mclk) disable iff (!resetn)
                balanceAllowed[gi] == (count[gi] != 14'h0000);
            endproperty
            a_halt_at_zero: assert property (p_halt_at_zero)
                else $error("balancing allowed at zero count");

            // without all enables the count holds
            property p_hold;
                @(posedge mclk) disable iff (!resetn)
                (!countEnable[gi] && !writeSel[gi]) |=>
                    count[gi] == $past(count[gi]);
            endproperty
            a_hold: assert property (p_hold)
                else $error("count moved while disabled");

            // enabled tick takes exactly one off
            property p_decrement;
                @(posedge mclk) disable iff (!resetn)
                (tick && countEnable[gi] && !writeSel[gi] &&
                 count[gi] != 14'h0000) |=>
                    count[gi] == $past(count[gi]) - 14'h0001;
            endproperty
            a_decrement: assert property (p_decrement)
                else $error("count not decremented by one");

            // count out of reset is zero
            property p_reset_zero;
                @(posedge mclk) disable iff (!resetn)
                !$past(resetn) |-> count[gi] == 14'h0000;
            endproperty
            a_reset_zero: assert property (p_reset_zero)
                else $error("count not zero after reset");

            // all-ones write gives the maximum count
            property p_max_load;
                @(posedge mclk) disable iff (!resetn)
                (writeSel[gi] && writeValue == 14'h3FFF) |=>
                    count[gi] == 14'h3FFF ##1
                    ($past(writeSel[gi]) || count[gi] >= 14'h3FFE);
            endproperty
            a_max_load: assert property (p_max_load)
                else $error("maximum count not held");

            // a count never grows unless written
            property p_no_wrap;
                @(posedge mclk) disable iff (!resetn)
                !writeSel[gi] |=> count[gi] <= $past(count[gi]);
            endproperty
            a_no_wrap: assert property (p_no_wrap)
                else $error("count grew without a write");

            // a non-zero load lets balancing run next cycle
            property p_allow_on_load;
                @(posedge mclk) disable iff (!resetn)
                (writeSel[gi] && writeValue != 14'h0000) |=>
                    balanceAllowed[gi];
            endproperty
            a_allow_on_load: assert property (p_allow_on_load)
                else $error("balancing not allowed after load");
        end
    endgenerate

    // reserved bits of read data are always zero
    property p_reserved_zero;
        @(posedge mclk) disable iff (!resetn)
        regRdata[`RESERVED_MSB:`RESERVED_LSB] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read non-zero");

    // a write to cell 5 leaves cell 6 alone
    property p_separate;
        @(posedge mclk) disable iff (!resetn)
        (writeSel[0] && !tick) |=> count[1] == $past(count[1]);
    endproperty
    a_separate: assert property (p_separate)
        else $error("write to cell 5 changed cell 6");

    // read data vanish after their one cycle
    property p_rdata_once;
        @(posedge mclk) disable iff (!resetn)
        (!regRead) |=> regRdata == 16'h0000;
    endproperty
    a_rdata_once: assert property (p_rdata_once)
        else $error("read data stood too long");

    // an unmapped write leaves both counts alone
    property p_unmapped_write;
        @(posedge mclk) disable iff (!resetn)
        (regWrite && hit == 2'h0 && !tick) |=>
            count[0] == $past(count[0]) && count[1] == $past(count[1]);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write)
        else $error("unmapped write changed a count");

    // an unmapped read answers zero
    property p_unmapped_read;
        @(posedge mclk) disable iff (!resetn)
        (regRead && hit == 2'h0) |=> regRdata == 16'h0000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned data");

    // cycles since the last tick, for the spacing checks
    logic [`TICK_COUNT_WIDTH-1:0] tickGap_q;   // cycles since last tick
    logic                         tickSeen_q;  // one tick passed since reset
    // tick spacing monitor
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tickGap_q  <= '0;
            tickSeen_q <= 1'b0;
        end else begin
            tickGap_q  <= tick ? '0 : tickGap_q + 1'b1;
            tickSeen_q <= tickSeen_q | tick;
        end
    end

    // ticks come exactly one period apart
    property p_tick_spacing;
        @(posedge mclk) disable iff (!resetn)
        (tick && tickSeen_q) |->
            tickGap_q == `TICK_COUNT_WIDTH'(TICK_CYCLES - 1);
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("tick spacing differs from period");

    // a tick never stays away longer than a period
    property p_tick_due;
        @(posedge mclk) disable iff (!resetn)
        tickGap_q <= `TICK_COUNT_WIDTH'(TICK_CYCLES);
    endproperty
    a_tick_due: assert property (p_tick_due)
        else $error("tick overdue");

    // a channel counts down to zero and stops
    property p_cover_expire;
        @(posedge mclk) disable iff (!resetn)
        $fell(balanceAllowed[0]);
    endproperty
    c_cover_expire: cover property (p_cover_expire);

    // write then read back the same register
    property p_cover_wr_rd;
        @(posedge mclk) disable iff (!resetn)
        writeSel[1] ##1 readSel[1];
    endproperty
    c_cover_wr_rd: cover property (p_cover_wr_rd);

    // a tick arrives while a channel is disabled
    property p_cover_held;
        @(posedge mclk) disable iff (!resetn)
        tick && !countEnable[0] && balanceAllowed[0];
    endproperty
    c_cover_held: cover property (p_cover_held);

    // the largest duration is loaded
    property p_cover_max;
        @(posedge mclk) disable iff (!resetn)
        writeSel[1] && writeValue == 14'h3FFF;
    endproperty
    c_cover_max: cover property (p_cover_max);

    // a write meets a tick on an enabled channel
    property p_cover_collide;
        @(posedge mclk) disable iff (!resetn)
        writeSel[0] && tick && countEnable[0];
    endproperty
    c_cover_collide: cover property (p_cover_collide);
endmodule

//--- cell_balance_timer_test.sv
`timescale 1ns/100ps
`include "cell_balance_timer_cfg.svh"

module cell_balance_timer_test;
    localparam int TICK = 8;  // short tick period for simulation
    // clock and reset
    logic                              mclk               = 1'b0;
    logic                              resetn             = 1'b0;
    // register port
    cell_balance_timer_pkg::reg_addr_t regAddr            = 16'h0000;
    cell_balance_timer_pkg::reg_word_t regWdata           = 16'h0000;
    logic                              regWrite           = 1'b0;
    logic                              regRead            = 1'b0;
    cell_balance_timer_pkg::reg_word_t regRdata;
    // balancing enables and permission
    logic                              balanceEnable      = 1'b0;
    logic                              timerBalanceEnable = 1'b0;
    logic [1:0]                        channelEnable      = 2'h0;
    logic [1:0]                        balanceAllowed;
    // bookkeeping
    int                                n_fail             = 0;
    int                                comparisons        = 0;
    logic [31:0]                       seed               = 32'hF49F;
    cell_balance_timer_pkg::reg_word_t rdVal;
    cell_balance_timer_pkg::duration_t n5, n6, exp5, exp6;
    int                                k;

    // free-running clock, 40 ns period
    always #20 mclk = ~mclk;

    cell_balance_timer #(.TICK_CYCLES(TICK)) u_cell_balance_timer (
        .mclk               (mclk),
        .resetn             (resetn),
        .regAddr            (regAddr),
        .regWdata           (regWdata),
        .regWrite           (regWrite),
        .regRead            (regRead),
        .regRdata           (regRdata),
        .balanceEnable      (balanceEnable),
        .timerBalanceEnable (timerBalanceEnable),
        .channelEnable      (channelEnable),
        .balanceAllowed     (balanceAllowed)
    );

    // next state of the stimulus generator
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // count left after some ticks, saturating at zero
    function automatic logic [13:0] expect_count(input logic [13:0] start,
                                                 input int ticks,
                                                 input logic active);
        if (!active) begin
            return start;
        end
        return (start > ticks) ? start - 14'(ticks) : 14'h0000;
    endfunction

    // compare and count
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // one-cycle write strobe
    task automatic reg_write(input logic [15:0] addr, input logic [15:0] data);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr  <= addr;
        regWdata <= data;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic reg_read(input logic [15:0] addr, output logic [15:0] data);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= addr;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        data = regRdata;
    endtask

    // counts and verdict, then stop
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (10000) @(posedge mclk);
        n_fail++;
        complete_run();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        // reset values
        reg_read(`CELL5_COUNTDOWN_OFFSET, rdVal);
        check("cell5 reset", rdVal, 16'h0000);
        reg_read(`CELL6_COUNTDOWN_OFFSET, rdVal);
        check("cell6 reset", rdVal, 16'h0000);
        check("allowed reset", {14'h0, balanceAllowed}, 16'h0000);
        $display("test reset done");
        // reserved bits, maximum value, address map
        reg_write(`CELL5_COUNTDOWN_OFFSET, 16'hFFFF);
        reg_write(16'h1024, 16'h0005);
        reg_write(16'h1027, 16'h0007);
        reg_read(`CELL5_COUNTDOWN_OFFSET, rdVal);
        check("cell5 max", rdVal, 16'h3FFF);
        @(posedge mclk);
        #1;
        check("read data idle", regRdata, 16'h0000);
        reg_read(16'h1027, rdVal);
        check("unmapped read", rdVal, 16'h0000);
        reg_read(`CELL6_COUNTDOWN_OFFSET, rdVal);
        check("cell6 untouched", rdVal, 16'h0000);
        $display("test map done");
        // countdown under every enable combination
        for (int c = 0; c < 32; c++) begin
            seed = lfsr(seed);
            n5   = c[4] ? 14'(seed[1:0]) : seed[13:0];
            seed = lfsr(seed);
            n6   = c[4] ? 14'h3FFF : seed[13:0];
            seed = lfsr(seed);
            k    = int'(seed[2:0]) + 1;
            reg_write(`CELL5_COUNTDOWN_OFFSET, {2'h3, n5});
            reg_write(`CELL6_COUNTDOWN_OFFSET, {2'h2, n6});
            reg_read(`CELL5_COUNTDOWN_OFFSET, rdVal);
            check("cell5 loaded", rdVal, {2'h0, n5});
            reg_read(`CELL6_COUNTDOWN_OFFSET, rdVal);
            check("cell6 loaded", rdVal, {2'h0, n6});
            @(posedge mclk);
            balanceEnable      <= c[3];
            timerBalanceEnable <= c[2];
            channelEnable      <= c[1:0];
            repeat (TICK * k) @(posedge mclk);
            balanceEnable      <= 1'b0;
            timerBalanceEnable <= 1'b0;
            channelEnable      <= 2'h0;
            exp5 = expect_count(n5, k, c[3] & c[2] & c[0]);
            exp6 = expect_count(n6, k, c[3] & c[2] & c[1]);
            reg_read(`CELL5_COUNTDOWN_OFFSET, rdVal);
            check("cell5 count", rdVal, {2'h0, exp5});
            reg_read(`CELL6_COUNTDOWN_OFFSET, rdVal);
            check("cell6 count", rdVal, {2'h0, exp6});
            check("allowed", {14'h0, balanceAllowed},
                  {14'h0, exp6 != 14'h0, exp5 != 14'h0});
        end
        $display("test countdown done");
        // reset in mid-run clears loaded counts
        reg_write(`CELL5_COUNTDOWN_OFFSET, 16'h0123);
        reg_read(`CELL5_COUNTDOWN_OFFSET, rdVal);
        check("cell5 before reset", rdVal, 16'h0123);
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        reg_read(`CELL5_COUNTDOWN_OFFSET, rdVal);
        check("cell5 mid reset", rdVal, 16'h0000);
        reg_read(`CELL6_COUNTDOWN_OFFSET, rdVal);
        check("cell6 mid reset", rdVal, 16'h0000);
        check("allowed cleared", {14'h0, balanceAllowed}, 16'h0000);
        $display("test mid reset done");
        complete_run();
    end
endmodule
